// ---- common/lpss_params.svh ----
// constants of the linear pixel scan sequencer: sizes, sequence points, timing counts
// included by the package, by the sensor and controller modules and by the testbench
`ifndef LPSS_PARAMS_SVH
`define LPSS_PARAMS_SVH

// array size and word widths
`define LPSS_NPIX 768
`define LPSS_PIX_W 12
`define LPSS_CNT_W 10

// sequence points, counted in link clock rising edges; the start edge is edge 1
`define LPSS_RST_HOLD_EDGES 17
`define LPSS_RELEASE_EDGE 19
`define LPSS_PRE_READ_PIX 18

// system clock period
`define LPSS_MCLK_PS 4000

// fastest link clock; half period is a least time, so it rounds up
`define LPSS_FCLK_MAX_KHZ 8000
`define LPSS_CLK_HALF_CYC ((1000000000 / `LPSS_FCLK_MAX_KHZ / 2 + `LPSS_MCLK_PS - 1) / `LPSS_MCLK_PS)
`define LPSS_HALF_W 5

// charge transfer wait, a least time, rounds up
`define LPSS_TQT_US 20
`define LPSS_TQT_CYC ((`LPSS_TQT_US * 1000000 + `LPSS_MCLK_PS - 1) / `LPSS_MCLK_PS)

// longest spacing of two start pulses, a longest time, rounds down
`define LPSS_TMAX_MS 100
`define LPSS_TMAX_CYC ((`LPSS_TMAX_MS * 1000000) / (`LPSS_MCLK_PS / 1000))
`define LPSS_SPACE_W 25

`endif

// ---- common/lpss_pkg.sv ----
// types of the linear pixel scan sequencer
// assumes lpss_params.svh is on the include path
`include "lpss_params.svh"

package lpss_pkg;

  typedef logic [`LPSS_PIX_W-1:0] lpss_pix_t;
  typedef logic [`LPSS_CNT_W-1:0] lpss_idx_t;
  typedef logic [`LPSS_SPACE_W-1:0] lpss_space_t;

  // controller sequence states, one-hot
  typedef enum logic [5:0] {
    LPSS_IDLE  = 6'b00_0001,
    LPSS_SETUP = 6'b00_0010,
    LPSS_HIGH  = 6'b00_0100,
    LPSS_LOW   = 6'b00_1000,
    LPSS_TQT   = 6'b01_0000,
    LPSS_GAP   = 6'b10_0000
  } lpss_state_t;

endpackage

// ---- common/lpss_if.sv ----
// link between the scan controller and one sensor section
// assumes both ends run on the same mclk; the analog output is a level plus an enable
`timescale 1ns/1ps

interface lpss_if;
  import lpss_pkg::*;

  logic link_clk;
  logic scan_start;
  logic hold_pulse;
  lpss_pix_t pixel_analog_output;
  logic pixel_oe;
  lpss_pix_t pixel_seen;

  // undriven output reads as zero
  assign pixel_seen = pixel_oe ? pixel_analog_output : '0;

  modport sensor (
    input link_clk,
    input scan_start,
    input hold_pulse,
    output pixel_analog_output,
    output pixel_oe
  );

  modport ctrl (
    output link_clk,
    output scan_start,
    output hold_pulse,
    input pixel_seen
  );
endinterface

// ---- design/lpss_skid.sv ----
// two-entry buffer with valid and ready on both sides
// assumes one clock; the output word is held in a flip-flop
`timescale 1ns/1ps

module lpss_skid #(
  parameter int WIDTH = 22
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic skid_valid;
  logic [WIDTH-1:0] skid_data;
  wire push = in_valid & in_ready;
  wire main_free = ~out_valid | out_ready;

  // ready only while the second entry is empty
  assign in_ready = ~skid_valid;

  // main entry refills from the skid entry first, keeping word order
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
      skid_valid <= 1'b0;
      skid_data <= '0;
    end else begin
      if (main_free) begin
        out_valid <= skid_valid | push;
        if (skid_valid) begin
          out_data <= skid_data;
        end else if (push) begin
          out_data <= in_data;
        end
      end
      if (skid_valid & main_free) begin
        skid_valid <= push;
        skid_data <= in_data;
      end else if (push & ~main_free) begin
        skid_valid <= 1'b1;
        skid_data <= in_data;
      end
    end
  end
endmodule

// ---- design/lpss_sensor.sv ----
// sensor section end: holds samples, sequences integrator reset and pixel readout
// assumes link pins are synchronous to mclk and the controller keeps its timing
`timescale 1ns/1ps
`include "lpss_params.svh"

module lpss_sensor
  import lpss_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  lpss_if.sensor link,
  input wire logic light_wr_en,
  input wire lpss_idx_t light_wr_addr,
  input wire lpss_pix_t light_wr_data,
  output logic integrator_reset_switch,
  output lpss_idx_t sample_select_switch,
  output logic readout_active
);

  localparam lpss_idx_t NPIX = `LPSS_CNT_W'(`LPSS_NPIX);
  localparam lpss_idx_t REL_EDGE = `LPSS_CNT_W'(`LPSS_RELEASE_EDGE);

  logic prev_clk;
  lpss_idx_t seq_cnt;
  lpss_pix_t light [0:`LPSS_NPIX-1];
  lpss_pix_t held_w [0:`LPSS_NPIX-1];
  lpss_pix_t out_level;
  logic out_en;

  // edge and sequence decode
  wire rise = link.link_clk & ~prev_clk;
  wire start_edge = rise & link.scan_start;
  wire cap_edge = rise & link.hold_pulse;
  wire step_edge = rise & ~link.scan_start & (seq_cnt != '0);
  wire lpss_idx_t next_cnt = seq_cnt + 10'h001;
  wire next_reads = next_cnt <= NPIX;
  wire lpss_idx_t next_sel = next_cnt - 10'h001;

  assign link.pixel_analog_output = out_level;
  assign link.pixel_oe = out_en;

  // scene writes into the photodiode levels
  always_ff @(posedge mclk) begin
    if (light_wr_en && light_wr_addr < NPIX) begin
      light[light_wr_addr] <= light_wr_data;
    end
  end

  // per-pixel sample capacitor with its tracking switch
  for (genvar i = 0; i < `LPSS_NPIX; i++) begin : g_pix
    logic track;
    lpss_pix_t held;
    wire reconnect = step_edge & ((i < `LPSS_PRE_READ_PIX) ? (next_cnt == REL_EDGE) :
                                  (next_cnt == `LPSS_CNT_W'(i + 2)));
    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        track <= 1'b1;
        held <= '0;
      end else begin
        if (cap_edge) begin
          track <= 1'b0;
        end else if (reconnect) begin
          track <= 1'b1;
        end
        if (track && !cap_edge) begin
          held <= integrator_reset_switch ? '0 : light[i];
        end
      end
    end
    assign held_w[i] = held;
  end

  // edge sampler and readout sequence counter
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_clk <= 1'b0;
      seq_cnt <= '0;
      integrator_reset_switch <= 1'b0;
      out_level <= '0;
      out_en <= 1'b0;
      sample_select_switch <= '0;
      readout_active <= 1'b0;
    end else begin
      prev_clk <= link.link_clk;
      if (start_edge) begin
        seq_cnt <= 10'h001;
        integrator_reset_switch <= 1'b1;
        out_level <= held_w[0];
        out_en <= 1'b1;
        sample_select_switch <= 10'h001;
        readout_active <= 1'b1;
      end else if (step_edge) begin
        seq_cnt <= next_reads ? next_cnt : '0;
        if (next_cnt == REL_EDGE) begin
          integrator_reset_switch <= 1'b0;
        end
        if (next_reads) begin
          out_level <= held_w[next_sel];
          sample_select_switch <= next_cnt;
        end else begin
          out_en <= 1'b0;
          sample_select_switch <= '0;
          readout_active <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- design/lpss_ctrl.sv ----
// Notes on behaviour
// - start pulse at clock edge begins cycle
// - at least n+1 clocks between starts
// - start spacing never exceeds 100 ms
// - start captures all pixels, presents pixel 1
// - each clock advances output to next pixel
// - integrators reset during start and 17 clocks
// - integration restarts on 19th rising edge
// - first 18 pixels read during reset
// - pixel tracks again one clock after read; pixels 1 to 17 rejoin at edge 19
// - clock n+1 ends readout, output undriven
// - wait charge transfer time before start
// - integration is start to hold minus 18
// - start and hold driven from one signal
// - clock at most 8 MHz, 768 pixels
// - first scan after power-up is discarded
// - clock parked low while idle
// - previous exposure read while next integrates
// - integration period kept under 100 ms
// - pixel valid whole period, sampled within it
// - start drops before next rising edge
//
// scan controller end: makes the link clock, start and hold pulses, samples pixels
// assumes the sensor samples link pins on the same mclk; user drains pixel words
`timescale 1ns/1ps
`include "lpss_params.svh"

module lpss_ctrl
  import lpss_pkg::*;
#(
  parameter int TQT_CYC = `LPSS_TQT_CYC,
  parameter int TMAX_CYC = `LPSS_TMAX_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  lpss_if.ctrl link,
  input wire logic scan_enable,
  input wire lpss_space_t integ_cycles,
  output logic pixel_valid,
  input wire logic pixel_ready,
  output lpss_pix_t pixel_data,
  output lpss_idx_t pixel_index,
  output logic scan_busy,
  output logic flush_done
);

  localparam int WORD_W = `LPSS_PIX_W + `LPSS_CNT_W;
  localparam lpss_idx_t NPIX = `LPSS_CNT_W'(`LPSS_NPIX);
  localparam logic [`LPSS_HALF_W-1:0] HALF_LAST = `LPSS_HALF_W'(`LPSS_CLK_HALF_CYC - 1);
  localparam lpss_space_t TQT_LAST = `LPSS_SPACE_W'(TQT_CYC - 1);
  localparam lpss_space_t TMAX = `LPSS_SPACE_W'(TMAX_CYC);
  localparam lpss_space_t START_LIMIT = `LPSS_SPACE_W'(TMAX_CYC - `LPSS_CLK_HALF_CYC - 2);

  lpss_state_t state;
  lpss_state_t next_state;
  logic [`LPSS_HALF_W-1:0] half_cnt;
  lpss_idx_t edge_cnt;
  lpss_space_t space_cnt;
  lpss_space_t wait_cnt;
  logic clk_q;
  logic start_q;
  logic discard;
  logic flush_pending;
  logic buf_in_ready;
  logic [WORD_W-1:0] buf_out;

  // sequence decode
  wire half_done = half_cnt == HALF_LAST;
  wire last_edge = edge_cnt == NPIX + 10'h001;
  wire tqt_done = wait_cnt == TQT_LAST;
  wire space_sat = space_cnt == TMAX;
  wire target_met = space_cnt >= integ_cycles;
  wire force_start = space_cnt >= START_LIMIT;
  wire sample_now = (state == LPSS_LOW) & half_done;
  wire may_rise = discard | buf_in_ready;
  wire push_valid = sample_now & ~discard;
  wire [WORD_W-1:0] push_word = {edge_cnt, link.pixel_seen};

  assign link.link_clk = clk_q;
  assign link.scan_start = start_q;
  assign link.hold_pulse = start_q;
  assign pixel_data = buf_out[`LPSS_PIX_W-1:0];
  assign pixel_index = buf_out[WORD_W-1:`LPSS_PIX_W];

  // next state of the scan sequence
  always_comb begin
    next_state = state;
    unique case (state)
      LPSS_IDLE: begin
        if (scan_enable) begin
          next_state = LPSS_SETUP;
        end
      end
      LPSS_SETUP: begin
        if (half_done) begin
          next_state = LPSS_HIGH;
        end
      end
      LPSS_HIGH: begin
        if (half_done) begin
          next_state = last_edge ? LPSS_TQT : LPSS_LOW;
        end
      end
      LPSS_LOW: begin
        if (half_done && may_rise) begin
          next_state = LPSS_HIGH;
        end
      end
      LPSS_TQT: begin
        if (tqt_done) begin
          next_state = LPSS_GAP;
        end
      end
      LPSS_GAP: begin
        if (!scan_enable) begin
          next_state = LPSS_IDLE;
        end else if (target_met || force_start) begin
          next_state = LPSS_SETUP;
        end
      end
      default: begin
        next_state = LPSS_IDLE;
      end
    endcase
  end

  // state and half period timer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= LPSS_IDLE;
      half_cnt <= '0;
    end else begin
      state <= next_state;
      if (next_state != state || half_done) begin
        half_cnt <= '0;
      end else if (state != LPSS_IDLE && state != LPSS_GAP && state != LPSS_TQT) begin
        half_cnt <= half_cnt + 5'h01;
      end
    end
  end

  // link clock and start pulse
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      if (next_state == LPSS_HIGH && state != LPSS_HIGH) begin
        clk_q <= 1'b1;
      end else if (state == LPSS_HIGH && half_done) begin
        clk_q <= 1'b0;
      end
      if (next_state == LPSS_SETUP && state != LPSS_SETUP) begin
        start_q <= 1'b1;
      end else if (state == LPSS_HIGH && half_done) begin
        start_q <= 1'b0;
      end
    end
  end

  // rising edge count, start spacing and charge transfer wait
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_cnt <= '0;
      space_cnt <= '0;
      wait_cnt <= '0;
    end else begin
      if (state == LPSS_SETUP && half_done) begin
        edge_cnt <= 10'h001;
      end else if (sample_now && may_rise) begin
        edge_cnt <= edge_cnt + 10'h001;
      end
      if (state == LPSS_SETUP && half_done) begin
        space_cnt <= '0;
      end else if (!space_sat) begin
        space_cnt <= space_cnt + 25'h000_0001;
      end
      if (state == LPSS_TQT) begin
        wait_cnt <= wait_cnt + 25'h000_0001;
      end else begin
        wait_cnt <= '0;
      end
    end
  end

  // stale data after power-up or an overlong gap is not passed on
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flush_pending <= 1'b1;
      discard <= 1'b1;
      flush_done <= 1'b0;
      scan_busy <= 1'b0;
    end else begin
      if (state == LPSS_SETUP && half_done) begin
        discard <= flush_pending;
        flush_pending <= 1'b0;
      end else if (space_sat) begin
        flush_pending <= 1'b1;
      end
      if (state == LPSS_TQT && tqt_done) begin
        flush_done <= 1'b1;
      end
      scan_busy <= next_state != LPSS_IDLE && next_state != LPSS_GAP;
    end
  end

  // pixel words sampled at the end of each period, stalling the clock when full
  lpss_skid #(
    .WIDTH(WORD_W)
  ) u_skid (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push_valid),
    .in_ready(buf_in_ready),
    .in_data(push_word),
    .out_valid(pixel_valid),
    .out_ready(pixel_ready),
    .out_data(buf_out)
  );
endmodule

// ---- verification/lpss_assertions.sv ----
// link wire checker between the scan controller and one sensor section
// assumes all link wires are flops on mclk; placed beside the link interface
`timescale 1ns/1ps

module lpss_assertions
  import lpss_pkg::*;
#(
  parameter int TQT_CYC = 20,
  parameter int TMAX_CYC = 60000
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic scan_start,
  input wire logic hold_pulse,
  input wire lpss_pix_t pixel_analog_output,
  input wire logic pixel_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [9:0] edges;
  logic [4:0] half_cnt;
  logic [24:0] since_start;
  logic [24:0] since_rise;

  // link edges since start, half period length, spacing counts
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      edges <= '0;
      half_cnt <= '0;
      since_start <= '0;
      since_rise <= 25'(TQT_CYC);
    end else begin
      edges <= !$rose(link_clk) ? edges : (scan_start ? 10'h1 : edges + 10'h1);
      half_cnt <= $changed(link_clk) ? 5'h0 : half_cnt + {4'h0, ~&half_cnt};
      since_start <= $rose(scan_start) ? 25'h0 : since_start + 25'h1;
      since_rise <= $rose(link_clk) ? 25'h0 : since_rise + 25'h1;
    end
  end

  start_hold_tie_a: assert property (hold_pulse == scan_start)
    else $error("hold and start differ");
  start_drop_a: assert property ($fell(link_clk) |-> !scan_start)
    else $error("start still high after clock fall");
  half_period_a: assert property ($changed(link_clk) |-> half_cnt >= 5'd15)
    else $error("link clock half period too short");
  start_oe_a: assert property ($rose(link_clk) && scan_start |=> pixel_oe)
    else $error("output not driven after start");
  oe_hold_a: assert property ($rose(link_clk) && !scan_start && edges inside {[1:767]}
    |=> pixel_oe)
    else $error("output dropped inside readout");
  oe_release_a: assert property ($rose(link_clk) && !scan_start && edges == 10'h300
    |=> !pixel_oe)
    else $error("output driven after last edge");
  start_order_a: assert property ($rose(scan_start) |-> edges == 10'h000 || edges == 10'h301)
    else $error("start before readout end");
  charge_wait_a: assert property ($rose(scan_start) |-> since_rise >= 25'(TQT_CYC))
    else $error("start too soon after last edge");
  spacing_max_a: assert property ($rose(scan_start) |-> since_start < 25'(TMAX_CYC))
    else $error("start spacing too long");
  out_stable_a: assert property (pixel_oe && !$rose(link_clk)
    |=> $stable(pixel_analog_output))
    else $error("pixel level moved inside a period");

  cover property ($rose(scan_start));
  cover property ($fell(pixel_oe));
  cover property ($rose(link_clk) && half_cnt > 5'd16);
  cover property ($rose(scan_start) && since_start > 25'(TMAX_CYC - 100));
endmodule

// ---- verification/tb_linear_pixel_scan_sequencer.sv ----
// self-checking bench: controller and sensor joined by the link interface
// assumes common and design files are compiled before this one
`timescale 1ns/1ps
`include "lpss_params.svh"

module tb_linear_pixel_scan_sequencer;
  import lpss_pkg::*;
  localparam int TQT = 20;
  localparam int TMAX = 30000;
  localparam int NPIX = `LPSS_NPIX;

  logic mclk;
  logic sys_rst;
  logic light_wr_en;
  lpss_idx_t light_wr_addr;
  lpss_pix_t light_wr_data;
  logic integrator_reset_switch;
  lpss_idx_t sample_select_switch;
  logic readout_active;
  logic scan_enable;
  lpss_space_t integ_cycles;
  logic pixel_valid;
  logic pixel_ready;
  lpss_pix_t pixel_data;
  lpss_idx_t pixel_index;
  logic scan_busy;
  logic flush_done;
  int num_errors;
  int total_checks;
  int words;
  int ecnt;
  int stall;
  int cyc;
  logic lprev;
  logic chk_due;
  logic [31:0] rnd;
  lpss_pix_t light_a [NPIX];
  lpss_pix_t light_b [NPIX];

  lpss_if link_bus ();

  lpss_sensor i_lpss_sensor (.mclk(mclk), .sys_rst(sys_rst), .link(link_bus),
    .light_wr_en(light_wr_en), .light_wr_addr(light_wr_addr), .light_wr_data(light_wr_data),
    .integrator_reset_switch(integrator_reset_switch),
    .sample_select_switch(sample_select_switch), .readout_active(readout_active));

  lpss_ctrl #(.TQT_CYC(TQT), .TMAX_CYC(TMAX)) i_lpss_ctrl (.mclk(mclk), .sys_rst(sys_rst),
    .link(link_bus), .scan_enable(scan_enable), .integ_cycles(integ_cycles),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready), .pixel_data(pixel_data),
    .pixel_index(pixel_index), .scan_busy(scan_busy), .flush_done(flush_done));

  lpss_assertions #(.TQT_CYC(TQT), .TMAX_CYC(TMAX)) i_lpss_assertions (.mclk(mclk),
    .sys_rst(sys_rst), .link_clk(link_bus.link_clk), .scan_start(link_bus.scan_start),
    .hold_pulse(link_bus.hold_pulse), .pixel_analog_output(link_bus.pixel_analog_output),
    .pixel_oe(link_bus.pixel_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // selector expected after link edge k
  function automatic lpss_idx_t exp_sel(input int k);
    return (k <= NPIX) ? lpss_idx_t'(k) : '0;
  endfunction

  // word n: first delivered scan shows table a, the next table b
  function automatic lpss_pix_t exp_pix(input int n);
    return (n < NPIX) ? light_a[n] : light_b[n - NPIX];
  endfunction

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // fill the light memory, then poke an address past the array
  task automatic write_light(input bit second);
    for (int i = 0; i < NPIX; i++) begin
      @(posedge mclk);
      light_wr_en <= 1'b1;
      light_wr_addr <= lpss_idx_t'(i);
      light_wr_data <= second ? rnd[23:12] : rnd[11:0];
      if (second) light_b[i] = rnd[23:12];
      else light_a[i] = rnd[11:0];
    end
    @(posedge mclk);
    light_wr_addr <= 10'h3ff;
    light_wr_data <= 12'h000;
    @(posedge mclk);
    light_wr_en <= 1'b0;
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 60000 && words < n; i++) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // sensor pins and controller busy one mclk after each link edge
  always @(negedge mclk) begin
    if (chk_due) begin
      check("select", 12'(exp_sel(ecnt)), 12'(sample_select_switch));
      check("int_reset", 12'(ecnt < 19), 12'(integrator_reset_switch));
      check("active", 12'(ecnt <= NPIX), 12'(readout_active));
      check("oe", 12'(ecnt <= NPIX), 12'(link_bus.pixel_oe));
      check("busy", 12'h001, 12'(scan_busy));
    end
    chk_due = !sys_rst && link_bus.link_clk && !lprev;
    if (chk_due) ecnt = link_bus.scan_start ? 1 : ecnt + 1;
    lprev = link_bus.link_clk;
  end

  // pixel stream drained with random and one long stall
  always @(posedge mclk) begin
    rnd <= lfsr(rnd);
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      close_out();
    end else if (!sys_rst) begin
      if (pixel_valid && pixel_ready) begin
        check("index", 12'(words % NPIX + 1), 12'(pixel_index));
        check("data", exp_pix(words), pixel_data);
        check("flushed", 12'h001, 12'(flush_done));
        words++;
        if (words == 100) stall = 200;
      end
      pixel_ready <= (stall == 0) && (rnd[5:4] != 2'b00);
      if (stall > 0) stall--;
    end
  end

  initial begin
    rnd = 32'h0000_32c9;
    sys_rst = 1'b1;
    light_wr_en = 1'b0;
    light_wr_addr = '0;
    light_wr_data = '0;
    scan_enable = 1'b0;
    integ_cycles = '0;
    pixel_ready = 1'b0;
    num_errors = 0;
    total_checks = 0;
    words = 0;
    ecnt = 0;
    stall = 0;
    cyc = 0;
    lprev = 1'b0;
    chk_due = 1'b0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    write_light(1'b0);
    integ_cycles <= 25'h61a8;
    scan_enable <= 1'b1;
    wait_words(1);
    // unreachable target: the next start comes from the longest-spacing limit
    integ_cycles <= 25'h1ff_ffff;
    write_light(1'b1);
    wait_words(2 * NPIX);
    scan_enable <= 1'b0;
    for (int i = 0; i < 300 && readout_active !== 1'b0; i++) @(posedge mclk);
    repeat (TQT) @(posedge mclk);
    check("clk_idle", 12'h000, 12'(link_bus.link_clk));
    check("count", 12'(2 * NPIX), 12'(words));
    repeat (40) @(posedge mclk);
    check("busy_idle", 12'h000, 12'(scan_busy));
    check("valid_idle", 12'h000, 12'(pixel_valid));
    close_out();
  end
endmodule
